// ---- common/pll_ctrl_pkg.sv ----
// Constants, field layout and decoders for the PLL lock-detect and calibration control.
// Assumes a 32-bit APB register bus and a clock at the phase-detector rate.
package pll_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 14;
  localparam logic [11:0] IDX_ABL      = 12'h017;
  localparam logic [11:0] IDX_LOCK     = 12'h018;
  localparam logic [11:0] IDX_UPDATE   = 12'h232;
  localparam logic [11:0] IDX_STATUS   = 12'h240;
  localparam logic [11:0] IDX_IRQ_STAT = 12'h241;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h242;
  localparam logic [13:0] ADDR_ABL      = {IDX_ABL, 2'b00};
  localparam logic [13:0] ADDR_LOCK     = {IDX_LOCK, 2'b00};
  localparam logic [13:0] ADDR_UPDATE   = {IDX_UPDATE, 2'b00};
  localparam logic [13:0] ADDR_STATUS   = {IDX_STATUS, 2'b00};
  localparam logic [13:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [13:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         ABL_LSB      = 0;
  localparam int         LOCK_CNT_LSB = 5;
  localparam int         WIN_BIT      = 4;
  localparam int         DIS_BIT      = 3;
  localparam int         DIV_LSB      = 1;
  localparam int         CAL_BIT      = 0;
  localparam int         UPDATE_BIT   = 0;
  localparam int         STAT_LOCK    = 0;
  localparam int         STAT_BUSY    = 1;
  localparam int         IRQ_LOCK_ACQ = 0;
  localparam int         IRQ_LOCK_LOST = 1;
  localparam int         IRQ_CAL_DONE = 2;
  localparam int         IRQ_W        = 3;
  localparam logic [7:0] ABL_RST      = 8'h00;
  localparam logic [7:0] LOCK_RST     = 8'h06;

  // ----------------------------------------------------------------------
  // Decode tables
  // ----------------------------------------------------------------------
  localparam logic [7:0]  LOCK_CNT_0 = 8'h05;
  localparam logic [7:0]  LOCK_CNT_1 = 8'h10;
  localparam logic [7:0]  LOCK_CNT_2 = 8'h40;
  localparam logic [7:0]  LOCK_CNT_3 = 8'hFF;
  localparam logic [12:0] ABL_PS_0   = 13'd2900;
  localparam logic [12:0] ABL_PS_1   = 13'd1300;
  localparam logic [12:0] ABL_PS_2   = 13'd6000;
  localparam logic [12:0] ABL_PS_3   = 13'd2900;
  localparam logic [4:0]  CAL_DIV_0  = 5'h02;
  localparam logic [4:0]  CAL_DIV_1  = 5'h04;
  localparam logic [4:0]  CAL_DIV_2  = 5'h08;
  localparam logic [4:0]  CAL_DIV_3  = 5'h10;

  typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;

  function automatic logic [7:0] lock_target(input logic [1:0] sel);
    unique case (sel)
      2'b00: lock_target = LOCK_CNT_0;
      2'b01: lock_target = LOCK_CNT_1;
      2'b10: lock_target = LOCK_CNT_2;
      2'b11: lock_target = LOCK_CNT_3;
    endcase
  endfunction : lock_target

  function automatic logic [12:0] abl_width_ps(input logic [1:0] sel);
    unique case (sel)
      2'b00: abl_width_ps = ABL_PS_0;
      2'b01: abl_width_ps = ABL_PS_1;
      2'b10: abl_width_ps = ABL_PS_2;
      2'b11: abl_width_ps = ABL_PS_3;
    endcase
  endfunction : abl_width_ps

  function automatic logic [4:0] cal_div(input logic [1:0] sel);
    unique case (sel)
      2'b00: cal_div = CAL_DIV_0;
      2'b01: cal_div = CAL_DIV_1;
      2'b10: cal_div = CAL_DIV_2;
      2'b11: cal_div = CAL_DIV_3;
    endcase
  endfunction : cal_div

  function automatic logic addr_mapped(input logic [13:0] a);
    addr_mapped = (a == ADDR_ABL) || (a == ADDR_LOCK) || (a == ADDR_UPDATE) ||
                  (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
  endfunction : addr_mapped

endpackage : pll_ctrl_pkg

// ---- common/cal_if.sv ----
// Link between the control registers and the calibration clock engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface cal_if;
  logic       trigger;
  logic [1:0] div_sel;
  logic       done_in;
  logic       cal_clk;
  logic       busy;
  logic       done_pulse;

  modport ctrl   (output trigger, div_sel, done_in, input cal_clk, busy, done_pulse);
  modport engine (input trigger, div_sel, done_in, output cal_clk, busy, done_pulse);
endinterface : cal_if
`default_nettype wire

// ---- design/osc_cal_engine.sv ----
// Calibration start detection and divided calibration clock.
// Assumes the trigger comes from the active register copy and done from the analog engine.
`timescale 1ns/1ns
`default_nettype none
module osc_cal_engine
(
  input  wire logic pclk,
  input  wire logic presetn,
  cal_if.engine     cif
);

  pll_ctrl_pkg::cal_state_t state_q;
  pll_ctrl_pkg::cal_state_t state_d;
  logic                     trig_prev_q;
  logic                     trig_prev_d;
  logic [3:0]               cnt_q;
  logic [3:0]               cnt_d;
  logic                     clk_q;
  logic                     clk_d;
  logic                     done_q;
  logic                     done_d;
  logic [4:0]               div;
  logic [3:0]               half_last;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    div         = pll_ctrl_pkg::cal_div(cif.div_sel); // R6
    half_last   = div[4:1] - 4'h1;
    trig_prev_d = cif.trigger;
    state_d     = state_q;
    cnt_d       = cnt_q;
    clk_d       = clk_q;
    done_d      = 1'b0;
    unique case (state_q)
      pll_ctrl_pkg::CAL_IDLE:
      begin
        cnt_d = 4'h0;
        clk_d = 1'b0;
        if (cif.trigger && !trig_prev_q) // R7
        begin
          state_d = pll_ctrl_pkg::CAL_RUN;
        end
      end
      pll_ctrl_pkg::CAL_RUN:
      begin
        if (cnt_q >= half_last) // R6
        begin
          cnt_d = 4'h0;
          clk_d = !clk_q;
        end
        else
        begin
          cnt_d = cnt_q + 4'h1;
        end
        if (cif.done_in)
        begin
          state_d = pll_ctrl_pkg::CAL_IDLE;
          done_d  = 1'b1;
          clk_d   = 1'b0;
          cnt_d   = 4'h0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= pll_ctrl_pkg::CAL_IDLE;
      trig_prev_q <= 1'b0;
      cnt_q       <= 4'h0;
      clk_q       <= 1'b0;
      done_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      trig_prev_q <= trig_prev_d;
      cnt_q       <= cnt_d;
      clk_q       <= clk_d;
      done_q      <= done_d;
    end
  end

  assign cif.cal_clk    = clk_q;
  assign cif.busy       = (state_q == pll_ctrl_pkg::CAL_RUN);
  assign cif.done_pulse = done_q;

endmodule : osc_cal_engine
`default_nettype wire

// ---- design/pll_lock_detect_vco_cal_ctrl.sv ----
// PLL control: antibacklash select, digital lock detection, calibration trigger.
// Assumes an APB master, pclk at the phase-detector rate and in-window flags per cycle.
//
// Contract
// R1 - The antibacklash field selects 2.9, 1.3, 6.0 or 2.9 ns for codes 00 to 11.
// R2 - Lock asserts after 5, 16, 64 or 255 consecutive in-window cycles per the count field.
// R3 - A cycle is in-window when the edge time difference is below the window time.
// R4 - Once set, lock holds until the difference exceeds the larger loss threshold.
// R5 - Lock configuration bit 3 enables detection at 0 (reset) and disables it at 1.
// R6 - The calibration clock is the reference divided by 2, 4, 8 or 16 (default 16).
// R7 - Calibration starts only on a 0 to 1 change of the trigger bit in the active copy.
// R8 - Software confirms the reference, writes trigger 0 plus update, then 1 plus update.
// R9 - While detection is disabled the lock flag and the cycle counter are held cleared.
`timescale 1ns/1ns
`default_nettype none
module pll_lock_detect_vco_cal_ctrl
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        edge_in_window,
  input  wire logic        edge_past_loss,
  input  wire logic        osc_cal_done,
  output logic             digital_lock_flag,
  output logic             lock_window_sel,
  output logic [1:0]       antibacklash_sel,
  output logic [12:0]      antibacklash_width_ps,
  output logic             osc_cal_clk,
  output logic             osc_cal_busy,
  output logic             irq
);

  cal_if cif ();

  logic                              pready_q;
  logic                              pready_d;
  logic [31:0]                       prdata_q;
  logic [31:0]                       prdata_d;
  logic                              pslverr_q;
  logic                              pslverr_d;
  logic [7:0]                        abl_stage_q;
  logic [7:0]                        abl_stage_d;
  logic [7:0]                        lock_stage_q;
  logic [7:0]                        lock_stage_d;
  logic [7:0]                        abl_act_q;
  logic [7:0]                        abl_act_d;
  logic [7:0]                        lock_act_q;
  logic [7:0]                        lock_act_d;
  logic [12:0]                       abl_ps_q;
  logic [12:0]                       abl_ps_d;
  logic                              lock_q;
  logic                              lock_d;
  logic [7:0]                        cnt_q;
  logic [7:0]                        cnt_d;
  logic [pll_ctrl_pkg::IRQ_W-1:0]    istat_q;
  logic [pll_ctrl_pkg::IRQ_W-1:0]    istat_d;
  logic [pll_ctrl_pkg::IRQ_W-1:0]    imask_q;
  logic [pll_ctrl_pkg::IRQ_W-1:0]    imask_d;
  logic                              irq_q;
  logic                              irq_d;
  logic                              setup;
  logic                              wr;
  logic [pll_ctrl_pkg::IRQ_W-1:0]    ev;
  logic [pll_ctrl_pkg::IRQ_W-1:0]    clr;
  logic [7:0]                        target;

  // ----------------------------------------------------------------------
  // Register bus and configuration copies
  // ----------------------------------------------------------------------
  always_comb
  begin
    setup        = psel && !penable;
    wr           = psel && penable && pready_q && pwrite;
    pready_d     = setup;
    pslverr_d    = setup && !pll_ctrl_pkg::addr_mapped(paddr);
    prdata_d     = 32'h0000_0000;
    abl_stage_d  = abl_stage_q;
    lock_stage_d = lock_stage_q;
    abl_act_d    = abl_act_q;
    lock_act_d   = lock_act_q;
    imask_d      = imask_q;
    clr          = '0;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        pll_ctrl_pkg::ADDR_ABL:      prdata_d = {24'h00_0000, abl_stage_q};
        pll_ctrl_pkg::ADDR_LOCK:     prdata_d = {24'h00_0000, lock_stage_q};
        pll_ctrl_pkg::ADDR_STATUS:
        begin
          prdata_d[pll_ctrl_pkg::STAT_LOCK] = lock_q;
          prdata_d[pll_ctrl_pkg::STAT_BUSY] = cif.busy;
        end
        pll_ctrl_pkg::ADDR_IRQ_STAT: prdata_d[pll_ctrl_pkg::IRQ_W-1:0] = istat_q;
        pll_ctrl_pkg::ADDR_IRQ_MASK: prdata_d[pll_ctrl_pkg::IRQ_W-1:0] = imask_q;
        default:                     prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      unique case (paddr)
        pll_ctrl_pkg::ADDR_ABL:      abl_stage_d  = pwdata[7:0];
        pll_ctrl_pkg::ADDR_LOCK:     lock_stage_d = pwdata[7:0];
        pll_ctrl_pkg::ADDR_UPDATE:
        begin
          if (pwdata[pll_ctrl_pkg::UPDATE_BIT])
          begin
            abl_act_d  = abl_stage_q;
            lock_act_d = lock_stage_q; // R7
          end
        end
        pll_ctrl_pkg::ADDR_IRQ_STAT: clr     = pwdata[pll_ctrl_pkg::IRQ_W-1:0];
        pll_ctrl_pkg::ADDR_IRQ_MASK: imask_d = pwdata[pll_ctrl_pkg::IRQ_W-1:0];
        default:                     clr     = '0;
      endcase
    end
    abl_ps_d = pll_ctrl_pkg::abl_width_ps(abl_act_d[pll_ctrl_pkg::ABL_LSB +: 2]); // R1
  end

  // ----------------------------------------------------------------------
  // Digital lock detection
  // ----------------------------------------------------------------------
  always_comb
  begin
    target = pll_ctrl_pkg::lock_target(lock_act_q[pll_ctrl_pkg::LOCK_CNT_LSB +: 2]); // R2
    lock_d = lock_q;
    cnt_d  = cnt_q;
    if (lock_act_q[pll_ctrl_pkg::DIS_BIT]) // R5
    begin
      lock_d = 1'b0; // R9
      cnt_d  = 8'h00; // R9
    end
    else if (lock_q)
    begin
      cnt_d = 8'h00;
      if (edge_past_loss) // R4
      begin
        lock_d = 1'b0;
      end
    end
    else if (edge_in_window) // R3
    begin
      if (cnt_q + 8'h01 >= target) // R2
      begin
        lock_d = 1'b1;
        cnt_d  = 8'h00;
      end
      else
      begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    else
    begin
      cnt_d = 8'h00; // R2
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  always_comb
  begin
    ev                                 = '0;
    ev[pll_ctrl_pkg::IRQ_LOCK_ACQ]     = lock_d && !lock_q;
    ev[pll_ctrl_pkg::IRQ_LOCK_LOST]    = !lock_d && lock_q;
    ev[pll_ctrl_pkg::IRQ_CAL_DONE]     = cif.done_pulse;
    istat_d                            = (istat_q & ~clr) | ev;
    irq_d                              = |(istat_d & imask_d);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q     <= 1'b0;
      prdata_q     <= 32'h0000_0000;
      pslverr_q    <= 1'b0;
      abl_stage_q  <= pll_ctrl_pkg::ABL_RST;
      lock_stage_q <= pll_ctrl_pkg::LOCK_RST;
      abl_act_q    <= pll_ctrl_pkg::ABL_RST;
      lock_act_q   <= pll_ctrl_pkg::LOCK_RST;
      abl_ps_q     <= pll_ctrl_pkg::ABL_PS_0;
      lock_q       <= 1'b0;
      cnt_q        <= 8'h00;
      istat_q      <= '0;
      imask_q      <= '0;
      irq_q        <= 1'b0;
    end
    else
    begin
      pready_q     <= pready_d;
      prdata_q     <= prdata_d;
      pslverr_q    <= pslverr_d;
      abl_stage_q  <= abl_stage_d;
      lock_stage_q <= lock_stage_d;
      abl_act_q    <= abl_act_d;
      lock_act_q   <= lock_act_d;
      abl_ps_q     <= abl_ps_d;
      lock_q       <= lock_d;
      cnt_q        <= cnt_d;
      istat_q      <= istat_d;
      imask_q      <= imask_d;
      irq_q        <= irq_d;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration engine
  // ----------------------------------------------------------------------
  assign cif.trigger = lock_act_q[pll_ctrl_pkg::CAL_BIT]; // R7
  assign cif.div_sel = lock_act_q[pll_ctrl_pkg::DIV_LSB +: 2]; // R6
  assign cif.done_in = osc_cal_done;

  osc_cal_engine u_cal
  (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif.engine)
  );

  assign pready                = pready_q;
  assign prdata                = prdata_q;
  assign pslverr               = pslverr_q;
  assign digital_lock_flag     = lock_q;
  assign lock_window_sel       = lock_act_q[pll_ctrl_pkg::WIN_BIT];
  assign antibacklash_sel      = abl_act_q[pll_ctrl_pkg::ABL_LSB +: 2]; // R1
  assign antibacklash_width_ps = abl_ps_q;
  assign osc_cal_clk           = cif.cal_clk;
  assign osc_cal_busy          = cif.busy;
  assign irq                   = irq_q;

endmodule : pll_lock_detect_vco_cal_ctrl
`default_nettype wire

// ---- verification/pll_ctrl_monitor.sv ----
// Port-level checks of the PLL lock-detect and calibration control.
// Assumes one clock domain; bound to the top module at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module pll_ctrl_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        edge_in_window,
  input wire logic        edge_past_loss,
  input wire logic        osc_cal_done,
  input wire logic        digital_lock_flag,
  input wire logic        lock_window_sel,
  input wire logic [1:0]  antibacklash_sel,
  input wire logic [12:0] antibacklash_width_ps,
  input wire logic        osc_cal_clk,
  input wire logic        osc_cal_busy,
  input wire logic        irq
);
  // --------
  // History
  // --------
  logic       wr_now;
  logic       upd_now;
  logic [2:0] wr_q;
  logic [2:0] wr_d;
  logic [2:0] upd_q;
  logic [2:0] upd_d;
  logic [2:0] win_q;
  logic [2:0] win_d;

  assign wr_now  = psel && penable && pwrite;
  assign upd_now = wr_now && (paddr == pll_ctrl_pkg::ADDR_UPDATE);

  always_comb
  begin
    wr_d  = {wr_q[1:0], wr_now};
    upd_d = {upd_q[1:0], upd_now};
    win_d = !edge_in_window ? 3'h0 : ((win_q == 3'h5) ? 3'h5 : win_q + 3'h1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q  <= 3'h0;
      upd_q <= 3'h0;
      win_q <= 3'h0;
    end
    else
    begin
      wr_q  <= wr_d;
      upd_q <= upd_d;
      win_q <= win_d;
    end
  end

  // --------
  // Properties
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  property p_apb_answer;
    s_setup |=> s_answer;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_idle_data;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_abl_width;
    antibacklash_width_ps == ((antibacklash_sel == 2'h1) ? 13'h514 :
                              ((antibacklash_sel == 2'h2) ? 13'h1770 : 13'hB54));
  endproperty
  property p_lock_rise;
    $rose(digital_lock_flag) |-> win_q == 3'h5;
  endproperty
  property p_no_win;
    !digital_lock_flag && !edge_in_window |=> !digital_lock_flag;
  endproperty
  property p_lock_hold;
    digital_lock_flag && !edge_past_loss && !wr_now && wr_q == 3'h0 |=> digital_lock_flag;
  endproperty
  property p_lock_loss;
    digital_lock_flag && edge_past_loss |=> !digital_lock_flag;
  endproperty
  property p_calclk_idle;
    !osc_cal_busy && !$past(osc_cal_busy) && !$past(osc_cal_busy, 2) |-> !osc_cal_clk;
  endproperty
  property p_calclk_toggle;
    osc_cal_busy && $changed(osc_cal_clk) |=> ##[0:7] (!osc_cal_busy || $changed(osc_cal_clk));
  endproperty
  property p_cal_start;
    $rose(osc_cal_busy) |-> upd_now || (upd_q != 3'h0);
  endproperty

  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not one cycle after setup");
  a_err_ready: assert property (p_err_ready)
    else $error("Error response without ready");
  a_idle_data: assert property (p_idle_data)
    else $error("Read data not zero outside answer");
  a_abl_width: assert property (p_abl_width)
    else $error("Antibacklash width does not match select");
  a_lock_rise: assert property (p_lock_rise)
    else $error("Lock rose without five in-window cycles");
  a_no_win: assert property (p_no_win)
    else $error("Lock rose after out-of-window cycle");
  a_lock_hold: assert property (p_lock_hold)
    else $error("Lock dropped without loss");
  a_lock_loss: assert property (p_lock_loss)
    else $error("Lock held past loss threshold");
  a_calclk_idle: assert property (p_calclk_idle)
    else $error("Calibration clock active while idle");
  a_calclk_toggle: assert property (p_calclk_toggle)
    else $error("Calibration clock half period too long");
  a_cal_start: assert property (p_cal_start)
    else $error("Calibration started without update");
endmodule : pll_ctrl_monitor

bind pll_lock_detect_vco_cal_ctrl pll_ctrl_monitor u_monitor (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .edge_in_window,
  .edge_past_loss, .osc_cal_done, .digital_lock_flag, .lock_window_sel, .antibacklash_sel,
  .antibacklash_width_ps, .osc_cal_clk, .osc_cal_busy, .irq);
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the PLL lock-detect and calibration control.
// Assumes one APB answer per access and one pclk per phase-detector cycle.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic        edge_in_window = 1'b0;
  logic        edge_past_loss = 1'b0;
  logic        osc_cal_done = 1'b0;
  logic        pready, pslverr, digital_lock_flag, lock_window_sel;
  logic        osc_cal_clk, osc_cal_busy, irq;
  logic [31:0] prdata;
  logic [1:0]  antibacklash_sel;
  logic [12:0] antibacklash_width_ps;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #10 pclk = ~pclk;

  pll_lock_detect_vco_cal_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .edge_in_window, .edge_past_loss, .osc_cal_done,
    .digital_lock_flag, .lock_window_sel, .antibacklash_sel, .antibacklash_width_ps,
    .osc_cal_clk, .osc_cal_busy, .irq);

  // --------
  // Tasks
  // --------
  task automatic print_verdict();
    $display("Checked %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_sig(ref logic s, input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (s !== v && n < 64);
    if (s !== v)
    begin
      chk(32'(s), 32'(v));
      print_verdict();
    end
  endtask : wait_sig

  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1)
    begin
      chk(32'(pready), 32'h1);
      print_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  task automatic cfg(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    apb(1'b1, pll_ctrl_pkg::ADDR_UPDATE, 32'h1);
    repeat (2) @(negedge pclk);
  endtask : cfg

  task automatic run(input int n, input logic v);
    repeat (n)
    begin
      @(posedge pclk);
      edge_in_window <= v;
    end
  endtask : run

  task automatic loss();
    @(posedge pclk);
    edge_past_loss <= 1'b1;
    @(posedge pclk);
    edge_past_loss <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : loss

  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    @(negedge pclk);
    chk(antibacklash_width_ps, 13'hB54);
    chk(digital_lock_flag, 1'b0);
    apb(1'b0, pll_ctrl_pkg::ADDR_ABL, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, pll_ctrl_pkg::ADDR_LOCK, 32'h0);
    chk(rdat, 32'h6);
    apb(1'b1, 14'h004, 32'hFF);
    chk(rerr, 1'b1);
    apb(1'b0, 14'h004, 32'h0);
    chk(rdat, 32'h0);
    chk(rerr, 1'b1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_abl();
    logic [12:0] w [4] = '{13'hB54, 13'h514, 13'h1770, 13'hB54};
    for (int c = 0; c < 4; c++)
    begin
      cfg(pll_ctrl_pkg::ADDR_ABL, 32'(c));
      chk(antibacklash_sel, 32'(c));
      chk(antibacklash_width_ps, w[c]);
    end
    $display("antibacklash test done");
  endtask : t_abl

  task automatic t_lock();
    int nn [4] = '{5, 16, 64, 255};
    for (int c = 0; c < 4; c++)
    begin
      cfg(pll_ctrl_pkg::ADDR_LOCK, 32'h6 | 32'(c << 5));
      run(nn[c] - 1, 1'b1);
      run(1, 1'b0);
      run(nn[c], 1'b1);
      @(negedge pclk);
      chk(digital_lock_flag, 1'b0);
      @(negedge pclk);
      chk(digital_lock_flag, 1'b1);
      run(4, 1'b0);
      @(negedge pclk);
      chk(digital_lock_flag, 1'b1);
      loss();
      chk(digital_lock_flag, 1'b0);
    end
    $display("lock test done");
  endtask : t_lock

  task automatic t_irq();
    cfg(pll_ctrl_pkg::ADDR_LOCK, 32'h6);
    apb(1'b1, pll_ctrl_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, pll_ctrl_pkg::ADDR_IRQ_STAT, 32'h7);
    run(6, 1'b1);
    run(1, 1'b0);
    loss();
    apb(1'b0, pll_ctrl_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(rdat, 32'h3);
    chk(irq, 1'b0);
    apb(1'b1, pll_ctrl_pkg::ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, pll_ctrl_pkg::ADDR_IRQ_STAT, 32'h2);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, pll_ctrl_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(rdat, 32'h1);
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_disable();
    run(6, 1'b1);
    repeat (2) @(negedge pclk);
    chk(digital_lock_flag, 1'b1);
    apb(1'b0, pll_ctrl_pkg::ADDR_STATUS, 32'h0);
    chk(rdat, 32'h1);
    cfg(pll_ctrl_pkg::ADDR_LOCK, 32'h1E);
    chk(digital_lock_flag, 1'b0);
    chk(lock_window_sel, 1'b1);
    run(20, 1'b1);
    @(negedge pclk);
    chk(digital_lock_flag, 1'b0);
    run(1, 1'b0);
    cfg(pll_ctrl_pkg::ADDR_LOCK, 32'h6);
    $display("disable test done");
  endtask : t_disable

  task automatic t_cal();
    int h;
    apb(1'b1, pll_ctrl_pkg::ADDR_IRQ_STAT, 32'h7);
    for (int c = 0; c < 4; c++)
    begin
      cfg(pll_ctrl_pkg::ADDR_LOCK, 32'(c << 1));
      cfg(pll_ctrl_pkg::ADDR_LOCK, 32'(c << 1) | 32'h1);
      wait_sig(osc_cal_busy, 1'b1);
      wait_sig(osc_cal_clk, 1'b0);
      wait_sig(osc_cal_clk, 1'b1);
      h = 0;
      while (osc_cal_clk === 1'b1 && h < 40)
      begin
        h++;
        @(negedge pclk);
      end
      chk(32'(h), 32'(1 << c));
      @(posedge pclk);
      osc_cal_done <= 1'b1;
      @(posedge pclk);
      osc_cal_done <= 1'b0;
      repeat (2) @(negedge pclk);
      chk(osc_cal_busy, 1'b0);
      apb(1'b0, pll_ctrl_pkg::ADDR_IRQ_STAT, 32'h0);
      chk(rdat & 32'h4, 32'h4);
      apb(1'b1, pll_ctrl_pkg::ADDR_IRQ_STAT, 32'h4);
    end
    cfg(pll_ctrl_pkg::ADDR_LOCK, 32'h7);
    apb(1'b1, pll_ctrl_pkg::ADDR_LOCK, 32'h6);
    apb(1'b1, pll_ctrl_pkg::ADDR_LOCK, 32'h7);
    repeat (6) @(negedge pclk);
    chk(osc_cal_busy, 1'b0);
    $display("calibration test done");
  endtask : t_cal

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_abl();
    t_lock();
    t_irq();
    t_disable();
    t_cal();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
